// ===== common/ccm_defs.svh
// Register map, field positions and reset values of the camera control core
`ifndef CCM_DEFS_SVH
`define CCM_DEFS_SVH
`define CCM_ADDR_STATUS   8'h18
`define CCM_ADDR_MASK     8'h1c
`define CCM_ADDR_CTRL     8'h40
`define CCM_ADDR_LEVEL    8'h44
`define CCM_CTRL_RESET    32'h0000_1001
`define CCM_CTRL_WMASK    32'h001f_3f1f
`define CCM_LEVEL_RESET   32'h0000_0007
`define CCM_LEVEL_WMASK   32'h0000_007f
`define CCM_EVT_WMASK     32'h0000_031f
`define CCM_BIT_SINGLE    20
`define CCM_BIT_RESYNC    19
`define CCM_BIT_SMRESET   18
`define CCM_BIT_FRAMEEND  17
`define CCM_BIT_ENABLE    16
`define CCM_EVT_FALSE     9
`define CCM_EVT_SHIFT     8
`define CCM_EVT_NOTEMPTY  4
`define CCM_EVT_FULL      3
`define CCM_EVT_LEVEL     2
`define CCM_EVT_OVERRUN   1
`define CCM_EVT_UNDERRUN  0
`define CCM_MODE_SEP8     4'h0
`define CCM_MODE_SEP10    4'h1
`define CCM_MODE_SEP12    4'h2
`define CCM_MODE_EMB8     4'h4
`define CCM_MODE_EMB10    4'h5
`define CCM_MODE_TEST     4'h7
`define CCM_MASK8         12'h0ff
`define CCM_MASK10        12'h3ff
`define CCM_MASK12        12'hfff
`endif

// ===== common/ccm_pkg.sv
// Types shared by the camera control core
package ccm_pkg;
  typedef enum logic [1:0] {
    CCM_IDLE    = 2'b00,
    CCM_WAIT    = 2'b01,
    CCM_CAPTURE = 2'b10
  } ccm_state_e;
endpackage

// ===== hdl/ccm_core.sv
// Camera core control, interrupt mask and sensor capture front end
//
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "ccm_defs.svh"

// Operation
// - A cleared mask bit blocks its event; a set bit lets it interrupt.
// - Mask bit 9 gates false sync code, bit 8 shifted sync code error.
// - Mask bit 4 gates the buffer-not-empty interrupt.
// - Mask bit 3 gates the buffer-full interrupt.
// - Mask bit 2 gates the buffer-level-exceeded interrupt.
// - Mask bit 1 gates the write-while-full interrupt.
// - Mask bit 0 gates the read-while-empty interrupt.
// - Bit 20 with enable captures one frame alone; reads zero.
// - Bit 19 adds input resync; set before enabling, high rates only.
// - Writing one to bit 18 resets all state machines; reads zero.
// - Bit 17 set: clearing enable stops capture at frame end.
// - Bit 17 clear: clearing enable stops capture immediately.
// - Bit 16 enables capture; clearing it disables per bit 17.
// - Protocol select picks 8/10/12 separate sync, 8/10 embedded, test.
// - Status bit reads one while pending; write one clears it.
module ccm_core (
  // Clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        arst_n_in,
  // Avalon-MM register slave
  input  wire logic [7:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  // Sensor pins
  input  wire logic        cam_pclk_in,
  input  wire logic        cam_vsync_in,
  input  wire logic        cam_hsync_in,
  input  wire logic [11:0] cam_data_in,
  // Sync code decoder and buffer status
  input  wire logic        false_sync_code_in,
  input  wire logic        shifted_sync_code_in,
  input  wire logic [7:0]  buffer_level_in,
  input  wire logic        buffer_full_in,
  input  wire logic        buffer_empty_in,
  input  wire logic        buffer_write_in,
  input  wire logic        buffer_read_in,
  // Capture output
  output logic             pixel_valid_out,
  output logic      [11:0] pixel_data_out,
  output logic             line_valid_out,
  output logic             capture_active_out,
  output logic             fsm_reset_out,
  output logic             irq_out
);

  // Register file
  logic [31:0] ctrl, next_ctrl;
  logic [31:0] mask, next_mask;
  logic [31:0] status, next_status;
  logic [31:0] level, next_level;
  logic [31:0] rdata, next_rdata;
  logic        ack, next_ack;
  logic        single, next_single;
  logic        smreset, next_smreset;
  logic [31:0] wmask;
  logic [31:0] events;
  logic        acc;
  logic        wr_ctrl;

  // Capture state
  ccm_pkg::ccm_state_e state, next_state;
  logic [14:0] sync1, sync2;
  logic [14:0] rsync, next_rsync;
  logic        pclk_d, next_pclk_d;
  logic        vs_d, next_vs_d;
  logic        pvalid, next_pvalid;
  logic [11:0] pdata, next_pdata;
  logic        lvalid, next_lvalid;
  logic [14:0] pins;
  logic        pclk_rise;
  logic        frame_start;
  logic        frame_end;
  logic        enable;
  logic [11:0] width_mask;

  assign acc     = avs_read_in | avs_write_in;
  assign wr_ctrl = avs_write_in & ack & (avs_address_in == `CCM_ADDR_CTRL);
  assign avs_waitrequest_out = acc & ~ack;
  assign avs_readdata_out    = rdata;
  assign enable              = ctrl[`CCM_BIT_ENABLE];
  assign fsm_reset_out       = smreset;
  assign capture_active_out  = (state == ccm_pkg::CCM_CAPTURE);
  assign pixel_valid_out     = pvalid;
  assign pixel_data_out      = pdata;
  assign line_valid_out      = lvalid;

  // Byte lanes to bit mask
  always_comb begin
    wmask = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
             {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
  end

  // Event sources
  always_comb begin
    events = 32'h0;
    events[`CCM_EVT_FALSE]    = false_sync_code_in;
    events[`CCM_EVT_SHIFT]    = shifted_sync_code_in;
    events[`CCM_EVT_NOTEMPTY] = ~buffer_empty_in;
    events[`CCM_EVT_FULL]     = buffer_full_in;
    events[`CCM_EVT_LEVEL]    = ({1'b0, buffer_level_in} >
                                 {2'b00, level[6:0]});
    events[`CCM_EVT_OVERRUN]  = buffer_write_in & buffer_full_in;
    events[`CCM_EVT_UNDERRUN] = buffer_read_in & buffer_empty_in;
  end

  // Register access, one wait state per transfer
  always_comb begin
    next_ctrl    = ctrl;
    next_mask    = mask;
    next_level   = level;
    next_status  = status;
    next_rdata   = rdata;
    next_ack     = acc & ~ack;
    next_single  = single;
    next_smreset = 1'b0;
    if (avs_write_in && ack) begin
      case (avs_address_in)
        `CCM_ADDR_CTRL: begin
          next_ctrl = (ctrl & ~(wmask & `CCM_CTRL_WMASK)) |
                      (avs_writedata_in & wmask & `CCM_CTRL_WMASK);
          next_smreset = avs_writedata_in[`CCM_BIT_SMRESET] &
                         avs_byteenable_in[2];
        end
        `CCM_ADDR_MASK: begin
          next_mask = (mask & ~(wmask & `CCM_EVT_WMASK)) |
                      (avs_writedata_in & wmask & `CCM_EVT_WMASK);
        end
        `CCM_ADDR_LEVEL: begin
          next_level = (level & ~(wmask & `CCM_LEVEL_WMASK)) |
                       (avs_writedata_in & wmask & `CCM_LEVEL_WMASK);
        end
        `CCM_ADDR_STATUS: begin
          next_status = status & ~(avs_writedata_in & wmask);
        end
        default: begin
          next_ctrl = ctrl;
        end
      endcase
    end
    // Set wins over clear
    next_status = (next_status | events) & `CCM_EVT_WMASK;
    // Pulse bits never hold; they read back as zero
    next_ctrl[`CCM_BIT_SMRESET] = 1'b0;
    next_ctrl[`CCM_BIT_SINGLE]  = 1'b0;
    if (wr_ctrl && avs_byteenable_in[2]) begin
      next_single = avs_writedata_in[`CCM_BIT_SINGLE] &
                    avs_writedata_in[`CCM_BIT_ENABLE];
    end
    // Single frame done: drop enable
    if (single && state == ccm_pkg::CCM_CAPTURE && frame_end) begin
      next_ctrl[`CCM_BIT_ENABLE] = 1'b0;
      next_single = 1'b0;
    end
    if (smreset) begin
      next_single = 1'b0;
    end
    if (acc && !ack) begin
      case (avs_address_in)
        `CCM_ADDR_CTRL:   next_rdata = ctrl;
        `CCM_ADDR_MASK:   next_rdata = mask;
        `CCM_ADDR_LEVEL:  next_rdata = level;
        `CCM_ADDR_STATUS: next_rdata = status;
        default:          next_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ctrl    <= `CCM_CTRL_RESET;
      mask    <= 32'h0;
      status  <= 32'h0;
      level   <= `CCM_LEVEL_RESET;
      rdata   <= 32'h0;
      ack     <= 1'b0;
      single  <= 1'b0;
      smreset <= 1'b0;
    end else begin
      ctrl    <= next_ctrl;
      mask    <= next_mask;
      status  <= next_status;
      level   <= next_level;
      rdata   <= next_rdata;
      ack     <= next_ack;
      single  <= next_single;
      smreset <= next_smreset;
    end
  end

  // Interrupt output from unmasked pending events
  always_comb begin
    irq_out = |(status & mask);
  end

  // Two-flop synchroniser for all sensor pins
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sync1 <= 15'h0;
      sync2 <= 15'h0;
    end else begin
      sync1 <= {cam_pclk_in, cam_vsync_in, cam_hsync_in, cam_data_in};
      sync2 <= sync1;
    end
  end

  // Optional extra alignment stage for all sensor pins
  always_comb begin
    next_rsync = sync2;
    pins = ctrl[`CCM_BIT_RESYNC] ? rsync : sync2;
  end

  // Data width per protocol select
  always_comb begin
    case (ctrl[3:0])
      `CCM_MODE_SEP8:  width_mask = `CCM_MASK8;
      `CCM_MODE_SEP10: width_mask = `CCM_MASK10;
      `CCM_MODE_SEP12: width_mask = `CCM_MASK12;
      `CCM_MODE_EMB8:  width_mask = `CCM_MASK8;
      `CCM_MODE_EMB10: width_mask = `CCM_MASK10;
      default:         width_mask = 12'h0;
    endcase
  end

  assign pclk_rise   = pins[14] & ~pclk_d;
  assign frame_start = pclk_rise & pins[13] & ~vs_d;
  assign frame_end   = pclk_rise & ~pins[13] & vs_d;

  // Capture state machine
  always_comb begin
    next_state  = state;
    next_pclk_d = pins[14];
    next_vs_d   = pclk_rise ? pins[13] : vs_d;
    next_pvalid = 1'b0;
    next_pdata  = pdata;
    next_lvalid = lvalid;
    case (state)
      ccm_pkg::CCM_IDLE: begin
        if (enable && ctrl[3:0] != `CCM_MODE_TEST) begin
          next_state = ccm_pkg::CCM_WAIT;
        end
      end
      ccm_pkg::CCM_WAIT: begin
        if (!enable) begin
          next_state = ccm_pkg::CCM_IDLE;
        end else if (frame_start) begin
          next_state = ccm_pkg::CCM_CAPTURE;
        end
      end
      ccm_pkg::CCM_CAPTURE: begin
        if (!enable && !ctrl[`CCM_BIT_FRAMEEND]) begin
          next_state = ccm_pkg::CCM_IDLE;
        end else if (frame_end) begin
          if (!enable || single) begin
            next_state = ccm_pkg::CCM_IDLE;
          end else begin
            next_state = ccm_pkg::CCM_WAIT;
          end
        end else if (pclk_rise && pins[12] && pins[13]) begin
          next_pvalid = 1'b1;
          next_pdata  = pins[11:0] & width_mask;
        end
        if (pclk_rise) begin
          next_lvalid = pins[12];
        end
      end
      default: begin
        next_state = ccm_pkg::CCM_IDLE;
      end
    endcase
    if (next_state != ccm_pkg::CCM_CAPTURE) begin
      next_lvalid = 1'b0;
    end
    if (smreset) begin
      next_state  = ccm_pkg::CCM_IDLE;
      next_vs_d   = 1'b0;
      next_pvalid = 1'b0;
      next_lvalid = 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state  <= ccm_pkg::CCM_IDLE;
      rsync  <= 15'h0;
      pclk_d <= 1'b0;
      vs_d   <= 1'b0;
      pvalid <= 1'b0;
      pdata  <= 12'h0;
      lvalid <= 1'b0;
    end else begin
      state  <= next_state;
      rsync  <= next_rsync;
      pclk_d <= next_pclk_d;
      vs_d   <= next_vs_d;
      pvalid <= next_pvalid;
      pdata  <= next_pdata;
      lvalid <= next_lvalid;
    end
  end

endmodule // ccm_core
`default_nettype wire

// ===== verification/ccm_core_checker.sv
// Assertions on the camera control core ports
`timescale 1ns/1ns
`default_nettype none
`include "ccm_defs.svh"
module ccm_core_checker (
  // Clock, reset and register bus
  input wire logic        core_clk_in,
  input wire logic        arst_n_in,
  input wire logic [7:0]  avs_address_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0]  avs_byteenable_in,
  input wire logic        avs_waitrequest_out,
  // Sensor and capture
  input wire logic        cam_vsync_in,
  input wire logic        pixel_valid_out,
  input wire logic [11:0] pixel_data_out,
  input wire logic        capture_active_out,
  input wire logic        fsm_reset_out,
  input wire logic        irq_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);
  logic       ctl_wr;
  logic       rst_req;
  logic [9:0] mask_sh;
  logic [3:0] mode_sh;
  assign ctl_wr = avs_write_in && !avs_waitrequest_out
    && avs_address_in == `CCM_ADDR_CTRL;
  assign rst_req = ctl_wr && avs_byteenable_in[2]
    && avs_writedata_in[`CCM_BIT_SMRESET];
  // Shadows of the mask and protocol select
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mask_sh <= 10'h000;
      mode_sh <= 4'h1;
    end else if (avs_write_in && !avs_waitrequest_out) begin
      if (avs_address_in == `CCM_ADDR_MASK && avs_byteenable_in == 4'hf)
        mask_sh <= avs_writedata_in[9:0] & 10'h31f;
      if (ctl_wr && avs_byteenable_in[0])
        mode_sh <= avs_writedata_in[3:0];
    end
  end
  chk_irq_needs_mask: assert property (
    irq_out |-> mask_sh != 10'h000) else $error("irq with no mask bit");
  chk_pixel_width: assert property (
    pixel_valid_out && mode_sh == `CCM_MODE_SEP8
    |-> pixel_data_out[11:8] == 4'h0) else $error("pixel width");
  chk_reset_pulse: assert property (
    fsm_reset_out |=> !fsm_reset_out) else $error("reset pulse long");
  chk_reset_cause: assert property (
    $rose(fsm_reset_out) |-> $past(rst_req)) else $error("stray reset");
  chk_reset_idle: assert property (
    fsm_reset_out |=> !capture_active_out) else $error("not idle");
  chk_stop_now: assert property (
    ctl_wr && avs_byteenable_in[2] && avs_writedata_in[17:16] == 2'b00
    |-> ##2 !capture_active_out) else $error("late stop");
  chk_hold_frame: assert property (
    ctl_wr && avs_byteenable_in[2] && avs_writedata_in[17:16] == 2'b10
    && capture_active_out && cam_vsync_in |=> capture_active_out)
    else $error("early stop");
  chk_pix_active: assert property (
    pixel_valid_out |-> capture_active_out || $past(capture_active_out)
    || $past(capture_active_out, 3)) else $error("pixel while idle");
endmodule // ccm_core_checker
bind ccm_core ccm_core_checker u_chk (
  .core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
  .avs_address_in(avs_address_in), .avs_write_in(avs_write_in),
  .avs_writedata_in(avs_writedata_in),
  .avs_byteenable_in(avs_byteenable_in),
  .avs_waitrequest_out(avs_waitrequest_out),
  .cam_vsync_in(cam_vsync_in), .pixel_valid_out(pixel_valid_out),
  .pixel_data_out(pixel_data_out),
  .capture_active_out(capture_active_out),
  .fsm_reset_out(fsm_reset_out), .irq_out(irq_out));
`default_nettype wire

// ===== verification/ccm_core_tb.sv
// Self-checking bench for the camera control core
`timescale 1ns/1ns
`default_nettype none
`include "ccm_defs.svh"
module ccm_core_tb;
  logic        clk = 0, rst_n = 0, rd = 0, wr = 0, go = 0;
  logic        wreq, busy, pclk, vs, hs, pv, act, irq, lv;
  logic        lvq = 0;
  logic [31:0] d2 = 32'h0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wd = 32'h0, rdat, q;
  logic [3:0]  be = 4'hf;
  logic [9:0]  ev = 10'h000;
  logic [11:0] cd, pd;
  logic [11:0] got [16];
  logic [3:0]  md [5] = '{`CCM_MODE_SEP8, `CCM_MODE_SEP10, `CCM_MODE_SEP12,
                          `CCM_MODE_EMB8, `CCM_MODE_EMB10};
  logic [11:0] mk [5] = '{`CCM_MASK8, `CCM_MASK10, `CCM_MASK12,
                          `CCM_MASK8, `CCM_MASK10};
  int          evb [7] = '{9, 8, 4, 3, 2, 1, 0};
  int          fails = 0, tests_run = 0, npix = 0, base, cnt;
  int          nln = 0, lbase, lcnt;
  always #10 clk = ~clk;
  always @(posedge clk) begin
    lvq <= lv;
    if (lv && !lvq) nln <= nln + 1;
    if (pv) begin
      got[npix[3:0]] <= pd;
      npix <= npix + 1;
    end
  end
  ccm_sensor_model cam (.go_in(go), .busy_out(busy), .pclk_out(pclk),
    .vsync_out(vs), .hsync_out(hs), .data_out(cd));
  ccm_core dut (.core_clk_in(clk), .arst_n_in(rst_n),
    .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wd), .avs_byteenable_in(be),
    .avs_readdata_out(rdat), .avs_waitrequest_out(wreq),
    .cam_pclk_in(pclk), .cam_vsync_in(vs), .cam_hsync_in(hs),
    .cam_data_in(cd), .false_sync_code_in(ev[9]),
    .shifted_sync_code_in(ev[8]), .buffer_level_in(ev[2] ? 8'h08 : 8'h00),
    .buffer_full_in(ev[3] | ev[1]), .buffer_empty_in(!ev[4]),
    .buffer_write_in(ev[1]), .buffer_read_in(ev[0]),
    .pixel_valid_out(pv), .pixel_data_out(pd), .line_valid_out(lv),
    .capture_active_out(act), .fsm_reset_out(), .irq_out(irq));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      fails++;
      $display("wrong value at %0t: %h, expected %h", $time, s, e);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] b);
    adr <= a;
    wd <= d;
    be <= b;
    wr <= w;
    rd <= !w;
    do @(posedge clk); while (wreq !== 1'b0);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic frame(input logic cut, input logic [31:0] d);
    base = npix;
    lbase = nln;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    while (cut && npix - base < 3) @(posedge clk);
    if (cut) bus(1, `CCM_ADDR_CTRL, d, 4'hf);
    if (cut && d2 != 32'h0) bus(1, `CCM_ADDR_CTRL, d2, 4'hf);
    while (busy) @(posedge clk);
    repeat (8) @(posedge clk);
    cnt = npix - base;
    lcnt = nln - lbase;
  endtask
  task automatic conclude();
    if (fails == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    conclude();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    bus(0, `CCM_ADDR_CTRL, 0, 4'hf);
    chk(q, `CCM_CTRL_RESET);
    bus(0, 8'h80, 0, 4'hf);
    chk(q, 0);
    bus(1, `CCM_ADDR_MASK, 32'hffff_ffff, 4'hf);
    bus(0, `CCM_ADDR_MASK, 0, 4'hf);
    chk(q, `CCM_EVT_WMASK);
    chk(irq, 0);
    foreach (evb[j]) begin
      bus(1, `CCM_ADDR_MASK, 0, 4'hf);
      ev[evb[j]] <= 1'b1;
      @(posedge clk);
      ev <= 10'h000;
      bus(1, `CCM_ADDR_STATUS, 0, 4'hf);
      bus(0, `CCM_ADDR_STATUS, 0, 4'hf);
      chk(q[evb[j]], 1);
      chk(irq, 0);
      bus(1, `CCM_ADDR_MASK, 1 << evb[j], 4'hf);
      chk(irq, 1);
      bus(1, `CCM_ADDR_STATUS, `CCM_EVT_WMASK, 4'hf);
      chk(irq, 0);
    end
    foreach (md[j]) begin
      bus(1, `CCM_ADDR_CTRL, 32'h0001_0000 | md[j], 4'hf);
      frame(0, 0);
      chk(cnt, 8);
      chk(lcnt, 2);
      for (int k = 0; k < 8; k++)
        chk(got[4'(base + k)], (12'hff0 + 12'(k)) & mk[j]);
      bus(1, `CCM_ADDR_CTRL, md[j], 4'hf);
    end
    bus(1, `CCM_ADDR_CTRL, 32'h0001_0007, 4'hf);
    frame(0, 0);
    chk(cnt, 0);
    bus(1, `CCM_ADDR_CTRL, 32'h0008_0000, 4'hf);
    bus(1, `CCM_ADDR_CTRL, 32'h0009_0000, 4'hf);
    frame(0, 0);
    chk(cnt, 8);
    bus(1, `CCM_ADDR_CTRL, 32'h0011_0000, 4'hf);
    frame(0, 0);
    chk(cnt, 8);
    bus(0, `CCM_ADDR_CTRL, 0, 4'hf);
    chk(q[20:16], 0);
    frame(0, 0);
    chk(cnt, 0);
    bus(1, `CCM_ADDR_CTRL, 32'h0003_0000, 4'hf);
    frame(1, 32'h0002_0000);
    chk(cnt, 8);
    chk(act, 0);
    bus(1, `CCM_ADDR_CTRL, 32'h0003_0000, 4'hf);
    d2 = 32'h0006_0000;
    frame(1, 32'h0002_0000);
    d2 = 32'h0;
    chk(cnt < 8, 1);
    chk(act, 0);
    bus(0, `CCM_ADDR_CTRL, 0, 4'hf);
    chk(q, 32'h0002_0000);
    bus(1, `CCM_ADDR_CTRL, 32'h0001_0000, 4'hf);
    frame(1, 0);
    chk(cnt < 8, 1);
    chk(act, 0);
    bus(1, `CCM_ADDR_CTRL, 32'h0000_1002, 4'hf);
    bus(1, `CCM_ADDR_CTRL, 32'h0004_0000, 4'h4);
    bus(0, `CCM_ADDR_CTRL, 0, 4'hf);
    chk(q, 32'h0000_1002);
    conclude();
  end
endmodule // ccm_core_tb
`default_nettype wire

// ===== verification/ccm_sensor_model.sv
// Camera sensor model sending one two-line frame per request
`timescale 1ns/1ns
`default_nettype none
module ccm_sensor_model (
  // Request and sensor pins
  input  wire logic        go_in,
  output logic             busy_out,
  output logic             pclk_out,
  output logic             vsync_out,
  output logic             hsync_out,
  output logic      [11:0] data_out
);
  initial begin
    busy_out = 1'b0;
    pclk_out = 1'b0;
    vsync_out = 1'b0;
    hsync_out = 1'b0;
    data_out = 12'h000;
  end
  // Pixel clock runs only while a request is served, two ticks past vsync fall
  task automatic tick();
    #80 pclk_out = 1'b1;
    #80 pclk_out = 1'b0;
  endtask
  always @(posedge go_in) begin
    #5;
    busy_out = 1'b1;
    vsync_out = 1'b1;
    tick();
    for (int l = 0; l < 2; l++) begin
      hsync_out = 1'b1;
      for (int p = 0; p < 4; p++) begin
        data_out = 12'hff0 + 12'(l * 4 + p);
        tick();
      end
      hsync_out = 1'b0;
      data_out = ~data_out;
      tick();
    end
    vsync_out = 1'b0;
    tick();
    tick();
    busy_out = 1'b0;
  end
endmodule // ccm_sensor_model
`default_nettype wire
